// >>> mcm_mailbox.v
/*
 * Command mailbox: twenty-word command buffer, command execution, status,
 * echo and reply registers, plus date keeping and broadcast to internal modules.
 * Assumes register accesses are single-cycle strobes synchronous to ref_clk,
 * one word per strobe, as a Modbus front end would deliver them.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcm_map.vh"
module mcm_mailbox #(
  parameter integer MS_CYCLES = `MCM_MS_CYCLES,
  parameter integer SYNC_MS = `MCM_SYNC_MS,
  parameter [15:0] CMD_SET_TIME = `MCM_CMD_SET_TIME
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire reg_rd,
  output reg [15:0] reg_rdata_q,
  output reg reg_rvalid_q,
  input wire ext_set_time,
  input wire [63:0] ext_datetime,
  output reg [63:0] now_datetime_q,
  output reg synced_q,
  output reg bcast_valid_q,
  output reg [63:0] bcast_datetime_q,
  output reg busy_q
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [15:0] buf_q [0:`MCM_BUF_WORDS-1];
  reg [2:0] state_q;
  reg [15:0] echo_q, status_q, rlen_q;
  reg [15:0] reply_md_q, reply_yh_q, reply_ms_q, reply_msec_q;
  reg [7:0] err_q;
  reg cmd_load_q;
  reg [63:0] cmd_time_q;
  reg [15:0] rd_d;
  wire [63:0] tk_now;
  wire tk_synced;
  wire tk_load;
  wire [63:0] tk_time;
  wire in_buf;
  wire [4:0] buf_idx;
  wire [15:0] buf_off;
  integer i;

  assign buf_off = reg_addr - `MCM_BUF_BASE;
  assign buf_idx = buf_off[4:0];
  assign in_buf = (reg_addr >= `MCM_BUF_BASE) && (reg_addr <= `MCM_BUF_LAST);
  // A command-driven load and a Modbus set-time in the same cycle: the pin wins.
  assign tk_load = ext_set_time | cmd_load_q; // RULE17
  assign tk_time = ext_set_time ? ext_datetime : cmd_time_q;

  mcm_timekeeper #(
    .MS_CYCLES(MS_CYCLES),
    .SYNC_MS(SYNC_MS)
  ) u_timekeeper (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(tk_load),
    .load_datetime(tk_time),
    .now_datetime(tk_now),
    .synced_q(tk_synced)
  );

  always @* begin
    rd_d = 16'h0000;
    if (in_buf) begin
      rd_d = buf_q[buf_idx];
    end else begin
      case (reg_addr)
        `MCM_ECHO: rd_d = echo_q;
        `MCM_STATUS: rd_d = status_q;
        `MCM_RLEN: rd_d = rlen_q;
        `MCM_REPLY_MD: rd_d = reply_md_q;
        `MCM_REPLY_YH: rd_d = reply_yh_q;
        `MCM_REPLY_MS: rd_d = reply_ms_q;
        `MCM_REPLY_MSEC: rd_d = reply_msec_q;
        default: rd_d = 16'h0000;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < `MCM_BUF_WORDS; i = i + 1) begin
        buf_q[i] <= `MCM_RST_WORD;
      end
      state_q <= ST_IDLE;
      echo_q <= `MCM_RST_WORD;
      status_q <= `MCM_RST_WORD;
      rlen_q <= `MCM_RST_WORD;
      reply_md_q <= `MCM_RST_WORD;
      reply_yh_q <= `MCM_RST_WORD;
      reply_ms_q <= `MCM_RST_WORD;
      reply_msec_q <= `MCM_RST_WORD;
      err_q <= `MCM_ERR_NONE;
      cmd_load_q <= 1'b0;
      cmd_time_q <= 64'h0;
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
      now_datetime_q <= 64'h0;
      synced_q <= 1'b0;
      bcast_valid_q <= 1'b0;
      bcast_datetime_q <= 64'h0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_d;
      end
      now_datetime_q <= tk_now; // RULE16
      synced_q <= tk_synced; // RULE14
      bcast_valid_q <= tk_load; // RULE15
      if (tk_load) begin
        bcast_datetime_q <= tk_time; // RULE15
      end
      cmd_load_q <= 1'b0;
      // The buffer stays writable while busy; execution samples it in ST_EXEC only.
      if (reg_wr && in_buf) begin
        buf_q[buf_idx] <= reg_wdata; // RULE1
      end
      case (state_q)
        ST_IDLE: begin
          // The write of the last buffer word closes the block write and launches it.
          if (reg_wr && (reg_addr == `MCM_BUF_LAST)) begin
            status_q <= `MCM_STAT_BUSY; // RULE3
            busy_q <= 1'b1;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Echo, reply length and reply words settle here, before ST_DONE writes status and clears busy.
          echo_q <= buf_q[0]; // RULE5 RULE19
          rlen_q <= 16'h0000;
          err_q <= `MCM_ERR_NONE;
          if (buf_q[0] == `MCM_CMD_READ_DATE) begin
            if (buf_q[1] > `MCM_FIXED_LEN) begin
              err_q <= `MCM_ERR_RANGE; // RULE8
            end else begin
              rlen_q <= `MCM_REPLY_LEN; // RULE9
              reply_md_q <= tk_now[63:48]; // RULE10
              reply_yh_q <= tk_now[47:32]; // RULE11
              reply_ms_q <= tk_now[31:16]; // RULE12
              reply_msec_q <= tk_now[15:0]; // RULE13
            end
          end else if (buf_q[0] == CMD_SET_TIME) begin
            if (buf_q[1] > `MCM_SET_LEN) begin
              err_q <= `MCM_ERR_RANGE; // RULE8
            end else begin
              cmd_time_q <= {buf_q[6], buf_q[7], buf_q[8], buf_q[9]};
              cmd_load_q <= 1'b1; // RULE17
            end
          end else begin
            err_q <= `MCM_ERR_UNKNOWN; // RULE7
          end
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          status_q <= {echo_q[15:8], err_q}; // RULE7 RULE19
          busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> mcm_map.vh
/*
 * Constants for the command mailbox with date and time keeping.
 * Assumes a 100 MHz ref_clk and 16-bit register words addressed by register address.
 */
// Behaviour
// RULE1 - Master writes twenty registers from buffer base
// RULE2 - Last three buffer words hold setup constants
// RULE3 - Status reads in-progress while command executes
// RULE4 - Master checks link after one second busy
// RULE5 - Echo register returns executed command code
// RULE6 - Master restarts sequence on echo mismatch
// RULE7 - Status low byte: zero success, else error
// RULE8 - Too many parameters gives error fifteen
// RULE9 - Read-date success sets reply length eight
// RULE10 - Reply word one: month high, day low
// RULE11 - Reply word two: year offset, hour
// RULE12 - Reply word three: minutes high, seconds low
// RULE13 - Reply word four: sixteen-bit milliseconds
// RULE14 - Synchronized only within two hours of sync
// RULE15 - Broadcast every newly received date and time; a command time in the same cycle as ext_set_time is not broadcast
// RULE16 - Modules stamp events with current date
// RULE17 - Accept set-time function or set-time command
// RULE18 - Read-date command: code 768, length ten
// RULE19 - Publish results before clearing in-progress status
`ifndef MCM_MAP_VH
`define MCM_MAP_VH
`define MCM_BUF_BASE 16'h1F40
`define MCM_BUF_LAST 16'h1F53
`define MCM_ECHO 16'h1F54
`define MCM_STATUS 16'h1F55
`define MCM_RLEN 16'h1F56
`define MCM_REPLY_MD 16'h1F57
`define MCM_REPLY_YH 16'h1F58
`define MCM_REPLY_MS 16'h1F59
`define MCM_REPLY_MSEC 16'h1F5A
`define MCM_BUF_WORDS 20
`define MCM_CMD_READ_DATE 16'h0300
`define MCM_CMD_SET_TIME 16'h0301
`define MCM_FIXED_LEN 16'h000A
`define MCM_SET_LEN 16'h0012
`define MCM_STAT_BUSY 16'h0003
`define MCM_ERR_NONE 8'h00
`define MCM_ERR_RANGE 8'h0F
`define MCM_ERR_UNKNOWN 8'h0E
`define MCM_REPLY_LEN 16'h0008
`define MCM_RST_WORD 16'h0000
`define MCM_RST_DAY 8'h01
`define MCM_RST_MONTH 8'h01
`define MCM_CLK_PERIOD_NS 10
`define MCM_MS_NS 1000000
`define MCM_MS_CYCLES (`MCM_MS_NS / `MCM_CLK_PERIOD_NS)
`define MCM_SYNC_HOURS 2
`define MCM_SYNC_MS (`MCM_SYNC_HOURS * 3600 * 1000)
`endif

// >>> mcm_timekeeper.v
/*
 * Running calendar clock with millisecond resolution and a sync-age flag.
 * Assumes load is a single-cycle pulse carrying a valid packed date and time.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcm_map.vh"
module mcm_timekeeper #(
  parameter integer MS_CYCLES = `MCM_MS_CYCLES,
  parameter integer SYNC_MS = `MCM_SYNC_MS
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire load,
  input wire [63:0] load_datetime,
  output wire [63:0] now_datetime,
  output reg synced_q
);
  reg [31:0] tick_q;
  reg [31:0] age_q;
  reg [7:0] month_q, day_q, year_q, hour_q, min_q, sec_q;
  reg [15:0] msec_q;
  wire ms_tick;

  // Leap years follow the four-year rule, which is exact for 2000 to 2099.
  function [7:0] days_in;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02: days_in = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
        8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
        default: days_in = 8'h1F;
      endcase
    end
  endfunction

  assign ms_tick = (tick_q == MS_CYCLES - 1);
  assign now_datetime = {month_q, day_q, year_q, hour_q, min_q, sec_q, msec_q}; // RULE16

  always @(posedge ref_clk) begin
    if (reset) begin
      tick_q <= 32'h0;
      age_q <= 32'h0;
      synced_q <= 1'b0;
      month_q <= `MCM_RST_MONTH;
      day_q <= `MCM_RST_DAY;
      year_q <= 8'h00;
      hour_q <= 8'h00;
      min_q <= 8'h00;
      sec_q <= 8'h00;
      msec_q <= 16'h0000;
    end else if (clk_en) begin
      if (load) begin
        {month_q, day_q, year_q, hour_q, min_q, sec_q, msec_q} <= load_datetime;
        tick_q <= 32'h0;
        age_q <= 32'h0;
        synced_q <= 1'b1; // RULE14
      end else begin
        tick_q <= ms_tick ? 32'h0 : tick_q + 32'h1;
        if (ms_tick && synced_q) begin
          age_q <= age_q + 32'h1;
          if (age_q == SYNC_MS - 1) begin
            synced_q <= 1'b0; // RULE14
          end
        end
        if (ms_tick) begin
          msec_q <= (msec_q == 16'h03E7) ? 16'h0000 : msec_q + 16'h1;
          if (msec_q == 16'h03E7) begin
            sec_q <= (sec_q == 8'h3B) ? 8'h00 : sec_q + 8'h1;
            if (sec_q == 8'h3B) begin
              min_q <= (min_q == 8'h3B) ? 8'h00 : min_q + 8'h1;
              if (min_q == 8'h3B) begin
                hour_q <= (hour_q == 8'h17) ? 8'h00 : hour_q + 8'h1;
                if (hour_q == 8'h17) begin
                  if (day_q == days_in(month_q, year_q)) begin
                    day_q <= `MCM_RST_DAY;
                    month_q <= (month_q == 8'h0C) ? `MCM_RST_MONTH : month_q + 8'h1;
                    if (month_q == 8'h0C) begin
                      year_q <= year_q + 8'h1;
                    end
                  end else begin
                    day_q <= day_q + 8'h1;
                  end
                end
              end
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> mcm_chk.sv
/* Port assertions for mcm_mailbox.
   Assumes clk_en stays high while a command or a time load is running. */
`timescale 1ns/100ps
`default_nettype none
module mcm_chk (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  input wire reg_rvalid_q,
  input wire ext_set_time,
  input wire [63:0] ext_datetime,
  input wire synced_q,
  input wire bcast_valid_q,
  input wire [63:0] bcast_datetime_q,
  input wire busy_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_go; clk_en && reg_wr && reg_addr == 16'h1F53 && !busy_q; endsequence
  sequence s_exec; busy_q [*2] ##1 !busy_q; endsequence
  sequence s_sync; clk_en && ext_set_time ##1 clk_en; endsequence
  busy_seq_a: assert property (s_go |=> s_exec)
    else $error("command busy window wrong");
  stat_busy_a: assert property (clk_en && reg_rd && reg_addr == 16'h1F55 && busy_q
    |=> reg_rdata_q == 16'h0003) else $error("status not in progress");
  rd_answer_a: assert property (clk_en && reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  unmap_rd_a: assert property (clk_en && reg_rd && reg_addr > 16'h1F5A |=> reg_rdata_q == 16'h0)
    else $error("unmapped read not zero");
  bcast_now_a: assert property (clk_en && ext_set_time
    |=> bcast_valid_q && bcast_datetime_q == $past(ext_datetime)) else $error("no broadcast");
  sync_set_a: assert property (s_sync |=> synced_q)
    else $error("sync not flagged");
  sync_hold_a: assert property ($rose(synced_q) |-> synced_q [*8])
    else $error("sync flag dropped early");
  reset_out_a: assert property ($fell(reset) |-> !busy_q && !synced_q && !bcast_valid_q)
    else $error("outputs not cleared by reset");
endmodule
bind mcm_mailbox mcm_chk u_chk (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .ext_set_time(ext_set_time), .ext_datetime(ext_datetime),
  .synced_q(synced_q), .bcast_valid_q(bcast_valid_q), .bcast_datetime_q(bcast_datetime_q),
  .busy_q(busy_q));
`default_nettype wire

// >>> mcm_master.sv
/* Register bus master model for the mailbox bench.
   Assumes its tasks are called just after a rising edge of ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module mcm_master (
  input wire logic ref_clk,
  output var logic [15:0] reg_addr,
  output var logic reg_wr,
  output var logic [15:0] reg_wdata,
  output var logic reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 34'h0;
  // One word per strobe, held until the next rising edge samples it.
  task bus(input logic w, r, input logic [15:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  // Gaps mimic a slow link; word 19 goes last since it starts the command.
  task cmd(input logic [15:0] c, l, input logic [63:0] t, input logic [31:0] g);
    int i;
    logic [15:0] v;
    for (i = 0; i < 20; i++) begin
      v = (i == 0 || i == 2) ? c : (i == 1) ? l : (i > 16) ? 16'h1F42 + i[15:0] : 16'h0;
      if (i > 5 && i < 10) v = t[63 - 16 * (i - 6) -: 16];
      bus(1'b1, 1'b0, 16'h1F40 + i[15:0], v);
      if (g[i] && i < 19) bus(1'b0, 1'b0, ~v, ~v);
    end
  endtask
endmodule
`default_nettype wire

// >>> mcm_mailbox_tb_top.sv
/* Self-checking bench for mcm_mailbox driven through mcm_master.
   Assumes mcm_chk is bound to the design by its own file. */
`timescale 1ns/100ps
`default_nettype none
module mcm_mailbox_tb_top;
  logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, ext_set_time = 1'b0;
  logic [63:0] ext_datetime = 64'h0, t;
  logic [31:0] rs = 32'hDB09A686, e, q[$];
  int error_cnt = 0, tests_run = 0, i, k;
  wire [15:0] reg_addr, reg_wdata, reg_rdata_q;
  wire reg_wr, reg_rd, reg_rvalid_q, synced_q, bcast_valid_q, busy_q;
  wire [63:0] now_datetime_q, bcast_datetime_q;
  always #5 ref_clk = ~ref_clk;
  mcm_master u_m (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // A short tick and sync window keep the expiry check within a few dozen cycles.
  mcm_mailbox #(.MS_CYCLES(4), .SYNC_MS(3)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .ext_set_time(ext_set_time), .ext_datetime(ext_datetime), .now_datetime_q(now_datetime_q),
    .synced_q(synced_q), .bcast_valid_q(bcast_valid_q), .bcast_datetime_q(bcast_datetime_q),
    .busy_q(busy_q));
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task check(input logic [63:0] seen, exp, input string n);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task idle;
    u_m.bus(1'b0, 1'b0, 16'h0, 16'h0);
  endtask
  task rd(input logic [15:0] a, x, m);
    q.push_back({m, x & m});
    u_m.bus(1'b0, 1'b1, a, 16'h0);
  endtask
  // An empty queue yields a note that can never match, so a stray answer is caught.
  always @(posedge ref_clk) begin
    if (reg_rvalid_q === 1'b1) begin
      e = q.size() ? q.pop_front() : 32'h1;
      check(reg_rdata_q & e[31:16], e[15:0], "rdata");
    end
  end
  task run(input logic [15:0] c, l, st, rl);
    rs = xs(rs);
    u_m.cmd(c, l, t, rs);
    rd(16'h1F55, 16'h0003, 16'hFFFF);
    for (i = 0; i == 0 || (i < 100 && busy_q === 1'b1); i++) idle;
    rd(16'h1F54, c, 16'hFFFF);
    rd(16'h1F55, st, 16'hFFFF);
    rd(16'h1F56, rl, 16'hFFFF);
  endtask
  // The millisecond word moves while the reply is built, so only its high byte is fixed.
  task reply;
    rd(16'h1F57, t[63:48], 16'hFFFF);
    rd(16'h1F58, t[47:32], 16'hFFFF);
    rd(16'h1F59, t[31:16], 16'hFFFF);
    rd(16'h1F5A, t[15:0], 16'hFF00);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(16'h1F55, 16'h0, 16'hFFFF);
    rd(16'h1F5B, 16'h0, 16'hFFFF);
    for (k = 0; k < 2; k++) begin
      rs = xs(rs);
      t = {8'(rs[3:0] % 12 + 1), 8'(rs[8:4] % 28 + 1), 8'(rs[15:9] % 100),
        8'(rs[20:16] % 24), 8'(rs[26:21] % 60), 3'h0, rs[31:27], 7'h0, rs[12], 8'h0};
      if (k == 0) begin
        ext_set_time <= 1'b1;
        ext_datetime <= t;
        idle;
        ext_set_time <= 1'b0;
        idle;
        check(bcast_valid_q, 1'b1, "bcast_valid");
        idle;
        check(bcast_valid_q, 1'b0, "bcast_valid");
        check(now_datetime_q[63:16], t[63:16], "now");
      end else begin
        run(16'h0301, 16'h0012, 16'h0300, 16'h0);
        check(synced_q, 1'b1, "synced");
      end
      check(bcast_datetime_q, t, "bcast");
      run(16'h0300, 16'h000A, 16'h0300, 16'h0008);
      reply;
    end
    run(16'h0300, 16'h000B, 16'h030F, 16'h0);
    run(16'h0301, 16'h0013, 16'h030F, 16'h0);
    run(16'h0500, 16'h000A, 16'h050E, 16'h0);
    // The last read answer must drain first, or a frozen valid would be seen again at every frozen edge.
    idle;
    clk_en <= 1'b0;
    idle;
    t = now_datetime_q;
    repeat (8) idle;
    check(now_datetime_q, t, "freeze");
    clk_en <= 1'b1;
    repeat (40) idle;
    check(synced_q, 1'b0, "synced");
    check(q.size(), 0, "pending");
    end_sim;
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
